// *** rtl/pfp_port_fault_ctrl.sv ***
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Overview of operation
// - Accessory supply overcurrent: retries, then shutdown
// - Shut port waits for disconnect to re-enable
// - Undervoltage or overvoltage: retries, then shutdown
// - Overcurrent or short circuit: same retry policy
// - Voltage fault thresholds and response times configurable
// - Current fault thresholds and response times configurable
// - CC overvoltage shuts port, no retries
// - CC overvoltage clears, port resumes by itself
// - Disconnect, fault, hard reset start discharge
// - Provider gate has off and on states
// - Optional slow turn-on, 2 to 10 ms
// - Standby pull-up under hardware control
// - Peak inductor current limit stops converter
module pfp_port_fault_ctrl #(
	parameter int MS_CYCLES = pfp_pkg::MS_CYCLES
) (
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [6:0]  FAULT_RAW,
	input  wire logic        ATTACHED,
	input  wire logic        HARD_RESET,
	output logic             PROVIDER_GATE_DRIVE,
	output logic             GATE_SLOW,
	output logic      [3:0]  SLOW_RAMP_MS,
	output logic             DISCHARGE,
	output logic             RP_HW_EN,
	output logic             CONV_EN,
	output logic      [7:0]  UV_THR,
	output logic      [7:0]  OV_THR,
	output logic      [7:0]  OC_THR,
	output logic      [7:0]  SC_THR,
	output logic      [7:0]  PEAK_LIMIT
);

	localparam int TMR_W = pfp_pkg::TMR_W;

	// ==========================================
	// Input synchronisers
	logic [7:0] sync1_q;
	logic [7:0] sync2_q;

	// Two stages for comparator flags and attach level
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			sync1_q <= 8'h00;
			sync2_q <= 8'h00;
		end else begin
			sync1_q <= {ATTACHED, FAULT_RAW};
			sync2_q <= sync1_q;
		end
	end

	wire logic [6:0] fault_s = sync2_q[6:0];
	wire logic       att_s   = sync2_q[7];
	logic            att_q;

	// Attach history for disconnect edge
	always_ff @(posedge CLK) begin
		if (SYS_RST) att_q <= 1'b0;
		else         att_q <= att_s;
	end

	wire logic disconnect = att_q & ~att_s;

	// ==========================================
	// Registers
	pfp_pkg::pfp_ctrl_s ctrl_q;
	logic [31:0]        thr_q;
	logic [31:0]        filt_q;
	logic [31:0]        ramp_q;
	logic [31:0]        peak_q;
	logic [7:0]         stat_q;
	logic [7:0]         stat_d;

	// Address decode
	wire logic wr_en   = PSEL & PENABLE & PWRITE;
	wire logic sel_ctl = (PADDR == pfp_pkg::CTRL_OFS);
	wire logic sel_thr = (PADDR == pfp_pkg::THR_OFS);
	wire logic sel_flt = (PADDR == pfp_pkg::FILT_OFS);
	wire logic sel_rmp = (PADDR == pfp_pkg::RAMP_OFS);
	wire logic sel_sta = (PADDR == pfp_pkg::STAT_OFS);
	wire logic sel_pk  = (PADDR == pfp_pkg::PEAK_OFS);
	wire logic mapped  = sel_ctl | sel_thr | sel_flt | sel_rmp | sel_sta | sel_pk;

	// Configuration writes
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ctrl_q <= pfp_pkg::CTRL_RST;
			thr_q  <= pfp_pkg::THR_RST;
			filt_q <= pfp_pkg::FILT_RST;
			ramp_q <= pfp_pkg::RAMP_RST;
			peak_q <= pfp_pkg::PEAK_RST;
		end else if (wr_en) begin
			if (sel_ctl) ctrl_q <= PWDATA;
			if (sel_thr) thr_q  <= PWDATA;
			if (sel_flt) filt_q <= PWDATA;
			if (sel_rmp) ramp_q <= {28'h000_0000, PWDATA[3:0]};
			if (sel_pk)  peak_q <= {24'h00_0000, PWDATA[7:0]};
		end
	end

	// Threshold outputs to analog comparators
	assign UV_THR     = thr_q[7:0];
	assign OV_THR     = thr_q[15:8];
	assign OC_THR     = thr_q[23:16];
	assign SC_THR     = thr_q[31:24];
	assign PEAK_LIMIT = peak_q[7:0];

	// ==========================================
	// Response time filters
	logic [6:0] fault_f;

	genvar gi;
	generate
		for (gi = 0; gi < pfp_pkg::N_FAULT; gi++) begin : g_filt
			localparam int GRP = (gi == 0) ? 0 : (gi < 3) ? 1 : (gi < 5) ? 2 : 3;
			logic [7:0] cnt_q;
			wire logic [7:0] lim = filt_q[GRP*8 +: 8];
			// Counts how long the flag has stood
			always_ff @(posedge CLK) begin
				if (SYS_RST)            cnt_q <= 8'h00;
				else if (!fault_s[gi])  cnt_q <= 8'h00;
				else if (cnt_q != lim)  cnt_q <= cnt_q + 8'h01;
			end
			assign fault_f[gi] = fault_s[gi] & (cnt_q == lim);
		end
	endgenerate

	// ==========================================
	// Fault classes
	pfp_pkg::pfp_state_e st_q;
	pfp_pkg::pfp_state_e st_d;
	logic [3:0]          rcnt_q [pfp_pkg::N_CLASS];

	wire logic active   = (st_q == pfp_pkg::ST_RAMP) | (st_q == pfp_pkg::ST_ON);
	wire logic [2:0] cls_hit = {
		ctrl_q.ocsc_en & (fault_f[pfp_pkg::F_OC] | fault_f[pfp_pkg::F_SC]),
		ctrl_q.uvov_en & (fault_f[pfp_pkg::F_UV] | fault_f[pfp_pkg::F_OV]),
		ctrl_q.vconn_en & fault_f[pfp_pkg::F_VCONN_OC]
	};
	wire logic [2:0] cls_spent;
	wire logic       ccov_trip = ctrl_q.ccov_en & fault_f[pfp_pkg::F_CC_OV];
	wire logic       any_hit   = active & (|cls_hit);
	wire logic       give_up   = |(cls_hit & cls_spent);
	wire logic       clr_cnt   = disconnect;

	// Per-class retry counters
	generate
		for (gi = 0; gi < pfp_pkg::N_CLASS; gi++) begin : g_retry
			assign cls_spent[gi] = (rcnt_q[gi] >= ctrl_q.retry_limit);
			always_ff @(posedge CLK) begin
				if (SYS_RST)
					rcnt_q[gi] <= 4'h0;
				else if (clr_cnt)
					rcnt_q[gi] <= 4'h0;
				else if (active && !ccov_trip && !give_up && cls_hit[gi])
					rcnt_q[gi] <= rcnt_q[gi] + 4'h1;
			end
		end
	endgenerate

	// ==========================================
	// Timer for ramp, retry back-off and discharge
	logic [TMR_W-1:0] tmr_q;
	logic [TMR_W-1:0] tmr_d;
	logic [TMR_W-1:0] dis_q;
	wire logic [3:0] ramp_ms =
		(ramp_q[3:0] < 4'(pfp_pkg::RAMP_MIN_MS)) ? 4'(pfp_pkg::RAMP_MIN_MS) :
		(ramp_q[3:0] > 4'(pfp_pkg::RAMP_MAX_MS)) ? 4'(pfp_pkg::RAMP_MAX_MS) :
		ramp_q[3:0];
	wire logic [TMR_W-1:0] ramp_cyc  = TMR_W'(ramp_ms * MS_CYCLES);
	wire logic [TMR_W-1:0] retry_cyc = TMR_W'(pfp_pkg::RETRY_MS * MS_CYCLES);
	wire logic [TMR_W-1:0] dis_cyc   = TMR_W'(pfp_pkg::DISCH_MS * MS_CYCLES);
	wire logic tmr_done = (tmr_q == '0);
	wire logic dis_busy = (dis_q != '0);
	wire logic dis_start = disconnect | HARD_RESET | (active & (any_hit | ccov_trip));

	// Next state
	always_comb begin
		st_d  = st_q;
		tmr_d = (tmr_q == '0) ? tmr_q : tmr_q - TMR_W'(1);
		case (st_q)
			pfp_pkg::ST_STANDBY: begin
				if (ccov_trip) begin
					st_d = pfp_pkg::ST_CCOV;
				end else if (att_s && ctrl_q.port_en && !dis_busy && !HARD_RESET) begin
					st_d  = pfp_pkg::ST_RAMP;
					tmr_d = ctrl_q.slow_en ? ramp_cyc : '0;
				end
			end
			pfp_pkg::ST_RAMP, pfp_pkg::ST_ON: begin
				if (ccov_trip) begin
					st_d = pfp_pkg::ST_CCOV;
				end else if (give_up) begin
					st_d = pfp_pkg::ST_SHUT;
				end else if (any_hit) begin
					st_d  = pfp_pkg::ST_RETRY;
					tmr_d = retry_cyc;
				end else if (disconnect || HARD_RESET || !ctrl_q.port_en) begin
					st_d = pfp_pkg::ST_STANDBY;
				end else if (st_q == pfp_pkg::ST_RAMP && tmr_done) begin
					st_d = pfp_pkg::ST_ON;
				end
			end
			pfp_pkg::ST_RETRY: begin
				if (ccov_trip) begin
					st_d = pfp_pkg::ST_CCOV;
				end else if (disconnect || !ctrl_q.port_en) begin
					st_d = pfp_pkg::ST_STANDBY;
				end else if (tmr_done && !dis_busy) begin
					st_d  = pfp_pkg::ST_RAMP;
					tmr_d = ctrl_q.slow_en ? ramp_cyc : '0;
				end
			end
			pfp_pkg::ST_SHUT: begin
				if (disconnect) st_d = pfp_pkg::ST_STANDBY;
			end
			pfp_pkg::ST_CCOV: begin
				if (!fault_f[pfp_pkg::F_CC_OV]) st_d = pfp_pkg::ST_STANDBY;
			end
			default: st_d = pfp_pkg::ST_STANDBY;
		endcase
	end

	// State, timer and discharge window
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			st_q  <= pfp_pkg::ST_STANDBY;
			tmr_q <= '0;
			dis_q <= '0;
		end else begin
			st_q  <= st_d;
			tmr_q <= tmr_d;
			dis_q <= dis_start ? dis_cyc : (dis_busy ? dis_q - TMR_W'(1) : dis_q);
		end
	end

	// ==========================================
	// Power path outputs, registered except SLOW_RAMP_MS (clamped from ramp_q)
	logic gate_q;
	logic slow_q;
	logic disch_q;
	logic rp_q;
	logic conv_q;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			gate_q  <= 1'b0;
			slow_q  <= 1'b0;
			disch_q <= 1'b0;
			rp_q    <= 1'b1;
			conv_q  <= 1'b0;
		end else begin
			gate_q  <= (st_d == pfp_pkg::ST_RAMP) | (st_d == pfp_pkg::ST_ON);
			slow_q  <= (st_d == pfp_pkg::ST_RAMP) & ctrl_q.slow_en;
			disch_q <= dis_start | (dis_q > TMR_W'(1));
			rp_q    <= (st_d == pfp_pkg::ST_STANDBY) & ~att_s;
			conv_q  <= ctrl_q.conv_en & ~(ctrl_q.peak_en & stat_d[pfp_pkg::F_PEAK]);
		end
	end

	assign PROVIDER_GATE_DRIVE = gate_q;
	assign GATE_SLOW           = slow_q;
	assign SLOW_RAMP_MS        = ramp_ms;
	assign DISCHARGE           = disch_q;
	assign RP_HW_EN            = rp_q;
	assign CONV_EN             = conv_q;

	// ==========================================
	// Sticky status, write one to clear, set wins
	wire logic [7:0] stat_set = {(st_d == pfp_pkg::ST_SHUT) & (st_q != pfp_pkg::ST_SHUT),
		fault_f};
	wire logic [7:0] stat_clr = (wr_en & sel_sta) ? PWDATA[7:0] : 8'h00;

	assign stat_d = (stat_q & ~stat_clr) | stat_set;

	always_ff @(posedge CLK) begin
		if (SYS_RST) stat_q <= 8'h00;
		else         stat_q <= stat_d;
	end

	// ==========================================
	// Read path
	wire logic [31:0] stat_rd = {16'h0000, rcnt_q[2], 1'b0, st_q, stat_q};
	wire logic [31:0] rd_mux =
		sel_ctl ? ctrl_q :
		sel_thr ? thr_q  :
		sel_flt ? filt_q :
		sel_rmp ? ramp_q :
		sel_sta ? stat_rd :
		sel_pk  ? peak_q : 32'h0000_0000;

	always_ff @(posedge CLK) begin
		if (SYS_RST) PRDATA <= 32'h0000_0000;
		else if (PSEL && !PENABLE && !PWRITE) PRDATA <= rd_mux;
	end

	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~mapped;

	// ==========================================
	// Assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	property p_shut_holds;
		(st_q == pfp_pkg::ST_SHUT) && att_s && !disconnect |=> (st_q == pfp_pkg::ST_SHUT) && !gate_q;
	endproperty
	a_shut_holds: assert property (p_shut_holds) else $error("Shut port left without disconnect");

	property p_uvov_limit;
		active && cls_hit[1] && cls_spent[1] && !ccov_trip |=> (st_q == pfp_pkg::ST_SHUT);
	endproperty
	a_uvov_limit: assert property (p_uvov_limit) else $error("Voltage fault limit missed");

	property p_retry_gate_off;
		active && any_hit && !give_up && !ccov_trip |=> (st_q == pfp_pkg::ST_RETRY) && !gate_q;
	endproperty
	a_retry_gate_off: assert property (p_retry_gate_off) else $error("Gate on at retry");

	property p_ccov_off;
		ccov_trip && (st_q != pfp_pkg::ST_SHUT) |=> !gate_q && (st_q == pfp_pkg::ST_CCOV);
	endproperty
	a_ccov_off: assert property (p_ccov_off) else $error("CC overvoltage left port on");

	property p_ccov_resume;
		(st_q == pfp_pkg::ST_CCOV) && !fault_f[pfp_pkg::F_CC_OV] |=> (st_q == pfp_pkg::ST_STANDBY);
	endproperty
	a_ccov_resume: assert property (p_ccov_resume) else $error("Port did not resume");

	property p_disch;
		disconnect || HARD_RESET |=> DISCHARGE [*2];
	endproperty
	a_disch: assert property (p_disch) else $error("Discharge not started");

	property p_peak;
		ctrl_q.peak_en && fault_f[pfp_pkg::F_PEAK] |=> !CONV_EN;
	endproperty
	a_peak: assert property (p_peak) else $error("Converter ran past peak limit");

	property p_rp_standby;
		(st_q == pfp_pkg::ST_STANDBY) && !att_s && $stable(st_q) |-> RP_HW_EN;
	endproperty
	a_rp_standby: assert property (p_rp_standby) else $error("Standby pull-up not in hardware");

	property p_slow;
		gate_q && !$past(gate_q) && ctrl_q.slow_en && $stable(ctrl_q) |-> GATE_SLOW;
	endproperty
	a_slow: assert property (p_slow) else $error("Slow turn-on missing");

	property p_sticky;
		fault_f[pfp_pkg::F_VCONN_OC] |=> stat_q[pfp_pkg::F_VCONN_OC];
	endproperty
	a_sticky: assert property (p_sticky) else $error("Fault flag not latched");

	property p_clear_cnt;
		clr_cnt |=> (rcnt_q[0] == 4'h0) && (rcnt_q[1] == 4'h0) && (rcnt_q[2] == 4'h0);
	endproperty
	a_clear_cnt: assert property (p_clear_cnt) else $error("Retry count not cleared");

endmodule : pfp_port_fault_ctrl

// *** rtl/pfp_pkg.sv ***
package pfp_pkg;

	// ==========================================
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] THR_OFS    = 8'h04;
	localparam logic [7:0] FILT_OFS   = 8'h08;
	localparam logic [7:0] RAMP_OFS   = 8'h0C;
	localparam logic [7:0] STAT_OFS   = 8'h10;
	localparam logic [7:0] PEAK_OFS   = 8'h14;

	// ==========================================
	// Fault flag positions
	localparam int F_VCONN_OC = 0;
	localparam int F_UV       = 1;
	localparam int F_OV       = 2;
	localparam int F_OC       = 3;
	localparam int F_SC       = 4;
	localparam int F_CC_OV    = 5;
	localparam int F_PEAK     = 6;
	localparam int N_FAULT    = 7;
	localparam int S_SHUTDOWN = 7;
	localparam int N_CLASS    = 3;

	// ==========================================
	// Status register fields
	localparam int STAT_STATE_LSB = 8;
	localparam int STAT_CNT_LSB   = 12;

	// ==========================================
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0300;
	localparam logic [31:0] THR_RST  = 32'h8080_8080;
	localparam logic [31:0] FILT_RST = 32'h0404_0404;
	localparam logic [31:0] RAMP_RST = 32'h0000_0002;
	localparam logic [31:0] PEAK_RST = 32'h0000_00C0;

	// ==========================================
	// Timing
	localparam int CLK_HZ       = 20_000_000;
	localparam int MS_PER_S     = 1000;
	localparam int MS_CYCLES    = CLK_HZ / MS_PER_S;
	localparam int RAMP_MIN_MS  = 2;
	localparam int RAMP_MAX_MS  = 10;
	localparam int RETRY_MS     = 5;
	localparam int DISCH_MS     = 2;
	localparam int TMR_W        = 24;

	// ==========================================
	// Control register layout
	typedef struct packed {
		logic [19:0] rsvd;
		logic [3:0]  retry_limit;
		logic        conv_en;
		logic        peak_en;
		logic        ccov_en;
		logic        ocsc_en;
		logic        uvov_en;
		logic        vconn_en;
		logic        slow_en;
		logic        port_en;
	} pfp_ctrl_s;

	// ==========================================
	// Port state machine
	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_RAMP,
		ST_ON,
		ST_RETRY,
		ST_SHUT,
		ST_CCOV
	} pfp_state_e;

endpackage : pfp_pkg

// *** verif/pfp_sink_model.sv ***
`timescale 1ns/1ps
// ==========================================
// Attached sink and cable on the connector
module pfp_sink_model (
	input  wire logic       gate_on,
	input  wire logic [6:0] fault_cmd,
	input  wire logic       attach_cmd,
	output logic      [6:0] fault_raw,
	output logic            attached
);
	// Rail faults only show while the provider switch feeds the load
	assign fault_raw[4:1] = fault_cmd[4:1] & {4{gate_on}};
	// Accessory, CC and converter faults do not depend on the switch
	assign fault_raw[0]   = fault_cmd[0];
	assign fault_raw[6:5] = fault_cmd[6:5];
	// Plug presence
	assign attached       = attach_cmd;
endmodule : pfp_sink_model

// *** verif/pfp_port_fault_ctrl_test.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin cmp_count++; if ((ac) !== (ex)) begin n_fail++; \
	$display("ERROR %s expected %h seen %h", nm, ex, ac); end end
module pfp_port_fault_ctrl_test;
	// ==========================================
	// Signals
	logic        clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, hard_reset = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic        pready, pslverr, gate, slow, disch, rp, conv, attached, attach_cmd = 0;
	logic [3:0]  ramp_ms;
	logic [7:0]  uv, ov, oc, sc, pk;
	logic [6:0]  fault_raw, cmd = 0;
	logic [31:0] rd;
	logic        er;
	int          n_fail = 0, cmp_count = 0;
	// ==========================================
	// Clock, design and partner
	always #25 clk = ~clk;
	pfp_port_fault_ctrl #(.MS_CYCLES(20)) u_pfp_port_fault_ctrl (.CLK(clk), .SYS_RST(sys_rst),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .FAULT_RAW(fault_raw),
		.ATTACHED(attached), .HARD_RESET(hard_reset), .PROVIDER_GATE_DRIVE(gate),
		.GATE_SLOW(slow), .SLOW_RAMP_MS(ramp_ms), .DISCHARGE(disch), .RP_HW_EN(rp),
		.CONV_EN(conv), .UV_THR(uv), .OV_THR(ov), .OC_THR(oc), .SC_THR(sc), .PEAK_LIMIT(pk));
	pfp_sink_model u_pfp_sink_model (.gate_on(gate), .fault_cmd(cmd), .attach_cmd(attach_cmd),
		.fault_raw(fault_raw), .attached(attached));
	// ==========================================
	// Bus and wait helpers
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Access phase lasts until ready; only the watchdog ends a hang
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wait_gate(input logic v);
		int i;
		for (i = 0; i < 2000 && gate !== v; i++) @(posedge clk);
		`CHK("gate", v, gate)
	endtask : wait_gate
	task stat_chk(input logic [2:0] st);
		apb(0, pfp_pkg::STAT_OFS, 0);
		`CHK("state", st, rd[10:8])
	endtask : stat_chk
	// ==========================================
	// Scenarios
	task t_reset_vals;
		apb(0, pfp_pkg::CTRL_OFS, 0); `CHK("ctrl", pfp_pkg::CTRL_RST, rd)
		apb(0, pfp_pkg::THR_OFS, 0);  `CHK("thr", pfp_pkg::THR_RST, rd)
		apb(0, pfp_pkg::FILT_OFS, 0); `CHK("filt", pfp_pkg::FILT_RST, rd)
		apb(0, pfp_pkg::RAMP_OFS, 0); `CHK("ramp", pfp_pkg::RAMP_RST, rd)
		apb(0, pfp_pkg::PEAK_OFS, 0); `CHK("peak", pfp_pkg::PEAK_RST, rd)
		apb(1, 8'h3C, 32'hFFFF_FFFF); `CHK("err w", 1'b1, er)
		apb(0, 8'h3C, 0); `CHK("unmapped", 33'h1_0000_0000, {er, rd})
		`CHK("ready", 1'b1, pready)
		`CHK("rp idle", 1'b1, rp)
		`CHK("gate idle", 1'b0, gate)
	endtask : t_reset_vals
	task t_config;
		apb(1, pfp_pkg::THR_OFS, 32'h1122_3344);
		// Written registers settle one edge after the access
		@(posedge clk);
		`CHK("thr out", 32'h1122_3344, {sc, oc, ov, uv})
		apb(1, pfp_pkg::FILT_OFS, 32'h0506_0708);
		apb(0, pfp_pkg::FILT_OFS, 0); `CHK("filt rb", 32'h0506_0708, rd)
		apb(1, pfp_pkg::PEAK_OFS, 32'h0000_005A);
		@(posedge clk);
		`CHK("peak out", 8'h5A, pk)
		apb(1, pfp_pkg::RAMP_OFS, 32'h0000_0001);
		@(posedge clk);
		`CHK("ramp lo", 4'h2, ramp_ms)
		apb(1, pfp_pkg::RAMP_OFS, 32'h0000_000F);
		@(posedge clk);
		`CHK("ramp hi", 4'hA, ramp_ms)
		apb(1, pfp_pkg::RAMP_OFS, 32'h0000_0002);
		apb(1, pfp_pkg::FILT_OFS, pfp_pkg::FILT_RST);
	endtask : t_config
	task t_slow_on;
		int i;
		apb(1, pfp_pkg::CTRL_OFS, 32'h0000_01FF);
		attach_cmd <= 1;
		wait_gate(1);
		`CHK("rp attached", 1'b0, rp)
		`CHK("slow", 1'b1, slow)
		repeat (30) @(posedge clk);
		`CHK("slow held", 1'b1, slow)
		for (i = 0; i < 40 && slow !== 1'b0; i++) @(posedge clk);
		`CHK("slow end", 1'b0, slow)
		apb(1, pfp_pkg::CTRL_OFS, 32'h0000_01FD);
	endtask : t_slow_on
	task t_retry_shut(input int b);
		apb(1, pfp_pkg::STAT_OFS, 32'h0000_00FF);
		wait_gate(1);
		cmd[b] <= 1;
		wait_gate(0);
		`CHK("discharge", 1'b1, disch)
		stat_chk(3'd3);
		`CHK("flag", 1'b1, rd[b])
		wait_gate(1);
		wait_gate(0);
		repeat (250) @(posedge clk);
		`CHK("shut held", 1'b0, gate)
		stat_chk(3'd4);
		`CHK("shut flag", 1'b1, rd[pfp_pkg::S_SHUTDOWN])
		cmd[b] <= 0;
		attach_cmd <= 0;
		repeat (10) @(posedge clk);
		stat_chk(3'd0);
		`CHK("count clr", 4'h0, rd[15:12])
		attach_cmd <= 1;
		wait_gate(1);
	endtask : t_retry_shut
	task t_ccov;
		cmd[pfp_pkg::F_CC_OV] <= 1;
		wait_gate(0);
		stat_chk(3'd5);
		cmd[pfp_pkg::F_CC_OV] <= 0;
		wait_gate(1);
		stat_chk(3'd2);
		`CHK("ccov flag", 1'b1, rd[pfp_pkg::F_CC_OV])
	endtask : t_ccov
	task t_class_off;
		apb(1, pfp_pkg::CTRL_OFS, 32'h0000_01ED);
		cmd[pfp_pkg::F_OC] <= 1;
		repeat (20) @(posedge clk);
		`CHK("class off gate", 1'b1, gate)
		stat_chk(3'd2);
		`CHK("class off flag", 1'b1, rd[pfp_pkg::F_OC])
		cmd[pfp_pkg::F_OC] <= 0;
		apb(1, pfp_pkg::CTRL_OFS, 32'h0000_01FD);
	endtask : t_class_off
	task t_peak;
		`CHK("conv on", 1'b1, conv)
		cmd[pfp_pkg::F_PEAK] <= 1;
		repeat (15) @(posedge clk);
		`CHK("conv trip", 1'b0, conv)
		cmd[pfp_pkg::F_PEAK] <= 0;
		repeat (5) @(posedge clk);
		apb(1, pfp_pkg::STAT_OFS, 32'h0000_00FF);
		repeat (3) @(posedge clk);
		`CHK("conv back", 1'b1, conv)
	endtask : t_peak
	task t_hard_reset;
		int i;
		@(posedge clk);
		hard_reset <= 1;
		@(posedge clk);
		hard_reset <= 0;
		for (i = 0; i < 5 && disch !== 1'b1; i++) @(posedge clk);
		`CHK("hr discharge", 1'b1, disch)
		wait_gate(1);
	endtask : t_hard_reset
	// ==========================================
	// Verdict and sequence
	task wrap_up;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		wrap_up();
	end
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 0;
		t_reset_vals();
		t_config();
		t_slow_on();
		t_retry_shut(pfp_pkg::F_OC);
		t_retry_shut(pfp_pkg::F_SC);
		t_retry_shut(pfp_pkg::F_UV);
		t_retry_shut(pfp_pkg::F_OV);
		t_retry_shut(pfp_pkg::F_VCONN_OC);
		t_ccov();
		t_peak();
		t_hard_reset();
		t_class_off();
		wrap_up();
	end
endmodule : pfp_port_fault_ctrl_test
